// File: design/preset_engine_defs.vh
// Constants for the event triggered preset engine
// Function
// - One master enable; while off no event row triggers any action.
// - Thirty-two event rows, each with its own criteria and action.
// - Row 0 has highest priority, falling with index to row 31.
// - Simultaneous triggers serviced lowest priority first; highest applied and logged last.
// - Each criterion bit is either don't care or a value to match.
// - Each row exposes an engaged status flag.
// - Row action: load user preset, fixed command, or alert.
// - Row configuration is never part of presets; presets cannot change it.
// - Layer-limited preset saves and restores only its layers' settings.
// - Layer select default all: save captures every setting unmasked.
// - While protected, save and delete are rejected.
// - Save stores current image, layer masked, under the supplied name.
// - Load applies the selected preset's stored changes at once.
// - Delete removes the selected preset.
// - Factory restore ignores layer select and resets every layer.
// - A row triggers only when all cared criteria are true together.
// - Triggers on onset; later loss neither disengages nor undoes.
// - History log of the five newest triggered events, newest first.
`ifndef PRESET_ENGINE_DEFS_VH
`define PRESET_ENGINE_DEFS_VH
`define ROWS          32
`define SLOTS         8
`define LOG_DEPTH     5
`define A_CTRL        10'h000
`define A_CMD         10'h004
`define A_NAME        10'h008
`define A_STAT        10'h00C
`define A_LIVE        10'h010
`define A_ENGAGED     10'h014
`define A_SLOT_NAME   10'h018
`define A_LOG_BASE    10'h020
`define A_LOG_END     10'h034
`define A_ROW_BASE    10'h080
`define A_ROW_END     10'h100
`define CTRL_RESET    32'h000000F0
`define CTRL_EN       0
`define CTRL_PROT     1
`define CTRL_LAYER_LO 4
`define CTRL_SEL_LO   8
`define CMD_SAVE      0
`define CMD_LOAD      1
`define CMD_DELETE    2
`define CMD_FACTORY   3
`define FACTORY_IMAGE 32'h00000000
`define ACT_NONE      2'h0
`define ACT_PRESET    2'h1
`define ACT_COMMAND   2'h2
`define ACT_ALERT     2'h3
`endif

// File: design/event_preset_engine.v
// Event triggered preset engine with Wishbone register slave
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "preset_engine_defs.vh"
module event_preset_engine (
	input  wire        CLK,
	input  wire        SRST,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [9:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire [7:0]  SIG_STATUS,
	output reg  [31:0] SETTINGS,
	output reg         CMD_STROBE,
	output reg  [5:0]  CMD_CODE,
	output reg         ALERT,
	output reg  [4:0]  ALERT_ROW
);

// =============================================================
// Register map
// 0x000 control: [0] event enable, [1] protect, [7:4] layer mask, [10:8] slot
// 0x004 command, write only: [0] save, [1] load, [2] delete, [3] factory
//       Factory beats load; save beats delete; only lane 0 is looked at
// 0x008 name used by the next save
// 0x00C status: [0] rejected (write 1 clears), [1] scanning, [15:8] slot valid
// 0x010 live settings, four layers of eight bits
// 0x014 engaged flag per row
// 0x018 name of the selected slot
// 0x020 to 0x030 history, newest first: [12:8] row, [7:6] action, [5:0] arg
// 0x080 to 0x0FC one word per row
//       [7:0] value, [15:8] care, [17:16] action, [23:18] arg, [31] enable
// Anything else reads zero and ignores writes
//
// Timing
// Every bus request is answered after one wait state.
// A row onset sets its pending bit; the scan then serves one row a cycle,
// highest index first, so row 0 acts last and ends up at the log top.
// A pass of N rows takes N cycles; onsets arriving mid pass join it.
// The action shows at the edge after a row is served.
//
// Limitations
// Row configuration is cleared by reset; card software restores it
// after power up, presets never touch it.
// Event enable low drops any pending rows at once, so a pass cut short
// by software leaves partial actions behind.
// A condition already true when events are enabled needs a fresh onset.
//
// Trade-offs
// One row per cycle keeps the action path narrow; a full pass of all
// rows costs 32 cycles, far below any detector update rate.
// An event action wins over a bus write to the live settings in the
// same cycle, since the event is the newer demand.

// =============================================================
// Helpers
function [31:0] lane_merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0]  sel;
	integer k;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			lane_merge[k*8 +: 8] = sel[k] ? data[k*8 +: 8] : old[k*8 +: 8];
		end
	end
endfunction

// Four layers of eight setting bits each
function [31:0] layer_bits;
	input [3:0] layers;
	begin
		layer_bits = {{8{layers[3]}}, {8{layers[2]}}, {8{layers[1]}}, {8{layers[0]}}};
	end
endfunction

// Lowest priority pending row is the highest index
function [4:0] last_set;
	input [31:0] v;
	integer k;
	begin
		last_set = 5'h00;
		for (k = 0; k < `ROWS; k = k + 1) begin
			if (v[k]) begin
				last_set = k[4:0];
			end
		end
	end
endfunction

// =============================================================
// Registers
localparam S_IDLE = 2'b01;
localparam S_SCAN = 2'b10;

reg  [31:0] ctrl;
reg  [31:0] save_name;
reg         rejected;
reg  [31:0] row_cfg   [0:31];
reg  [31:0] slot_img  [0:7];
reg  [31:0] slot_name [0:7];
reg  [3:0]  slot_mask [0:7];
reg  [7:0]  slot_valid;
reg  [31:0] engaged;
reg  [31:0] cond_prev;
reg  [31:0] pending;
reg  [12:0] log_ent   [0:4];
reg  [1:0]  state;
reg  [1:0]  next_state;
reg  [31:0] cond_now;
reg  [31:0] onset;
reg  [31:0] cfg_wr;
integer     i;

wire        req     = WB_CYC_I & WB_STB_I;
wire        wr_now  = req & WB_WE_I & WB_ACK_O;
wire        in_rows = (WB_ADR_I >= `A_ROW_BASE) && (WB_ADR_I < `A_ROW_END);
wire [4:0]  wr_row  = WB_ADR_I[6:2];
wire [2:0]  sel_slot = ctrl[`CTRL_SEL_LO +: 3];
wire [3:0]  layers   = ctrl[`CTRL_LAYER_LO +: 4];
wire        cmd_wr   = wr_now & (WB_ADR_I == `A_CMD) & WB_SEL_I[0];
wire        prot     = ctrl[`CTRL_PROT];
wire [4:0]  svc      = last_set(pending);
wire [31:0] svc_cfg  = row_cfg[svc];
wire [1:0]  svc_act  = svc_cfg[17:16];
wire [5:0]  svc_arg  = svc_cfg[23:18];
wire        scanning = state == S_SCAN;
// Serve only a real pending row while enabled; a disable mid pass must not act on row 0
wire        svc_go   = scanning && ctrl[`CTRL_EN] && (pending != 32'h00000000);

// Row layout: [7:0] match value, [15:8] care mask, [17:16] action, [23:18] arg, [31] row enable
always @* begin
	cond_now = 32'h00000000;
	cfg_wr   = 32'h00000000;
	for (i = 0; i < `ROWS; i = i + 1) begin
		cond_now[i] = row_cfg[i][31] &
			(((SIG_STATUS ^ row_cfg[i][7:0]) & row_cfg[i][15:8]) == 8'h00);
		cfg_wr[i] = wr_now & in_rows & (wr_row == i[4:0]);
	end
	onset = cond_now & ~cond_prev & {32{ctrl[`CTRL_EN]}};
end

always @* begin
	case (state)
		S_IDLE:  next_state = (pending != 32'h00000000) ? S_SCAN : S_IDLE;
		S_SCAN:  next_state = ((pending & ~(32'h00000001 << svc)) == 32'h00000000 && onset == 32'h00000000)
			? S_IDLE : S_SCAN;
		default: next_state = S_IDLE;
	endcase
end

// =============================================================
// Bus slave: one wait state, ack drops the cycle after it is given
always @(posedge CLK) begin
	if (SRST) begin
		WB_ACK_O <= 1'b0;
		WB_DAT_O <= 32'h00000000;
	end else begin
		WB_ACK_O <= req & ~WB_ACK_O;
		WB_DAT_O <= 32'h00000000;
		if (req & ~WB_ACK_O & ~WB_WE_I) begin
			if (in_rows) begin
				WB_DAT_O <= row_cfg[wr_row];
			end else if (WB_ADR_I >= `A_LOG_BASE && WB_ADR_I < `A_LOG_END) begin
				WB_DAT_O <= {19'h00000, log_ent[WB_ADR_I[4:2]]};
			end else begin
				case (WB_ADR_I)
					`A_CTRL:      WB_DAT_O <= ctrl;
					`A_NAME:      WB_DAT_O <= save_name;
					`A_STAT:      WB_DAT_O <= {16'h0000, slot_valid, 6'h00, scanning, rejected};
					`A_LIVE:      WB_DAT_O <= SETTINGS;
					`A_ENGAGED:   WB_DAT_O <= engaged;
					`A_SLOT_NAME: WB_DAT_O <= slot_name[sel_slot];
					default:      WB_DAT_O <= 32'h00000000;
				endcase
			end
		end
	end
end

// =============================================================
// Event rows, scan and history
always @(posedge CLK) begin
	if (SRST) begin
		state     <= S_IDLE;
		cond_prev <= 32'h00000000;
		pending   <= 32'h00000000;
		engaged   <= 32'h00000000;
		for (i = 0; i < `ROWS; i = i + 1) begin
			row_cfg[i] <= 32'h00000000;
		end
		for (i = 0; i < `LOG_DEPTH; i = i + 1) begin
			log_ent[i] <= 13'h0000;
		end
	end else begin
		state     <= next_state;
		cond_prev <= cond_now;
		// Reconfiguring a row ends its engaged state; a service in the same cycle wins
		engaged   <= (engaged & ~cfg_wr) | (svc_go ? (32'h00000001 << svc) : 32'h00000000);
		if (!ctrl[`CTRL_EN]) begin
			pending <= 32'h00000000;
		end else begin
			pending <= (pending & ~(svc_go ? (32'h00000001 << svc) : 32'h00000000)) | onset;
		end
		for (i = 0; i < `ROWS; i = i + 1) begin
			if (cfg_wr[i]) begin
				row_cfg[i] <= lane_merge(row_cfg[i], WB_DAT_I, WB_SEL_I);
			end
		end
		if (svc_go) begin
			// Newest entry on top; highest priority row lands there last
			log_ent[0] <= {svc, svc_act, svc_arg};
			for (i = 1; i < `LOG_DEPTH; i = i + 1) begin
				log_ent[i] <= log_ent[i-1];
			end
		end
	end
end

// =============================================================
// Actions and preset store
always @(posedge CLK) begin
	if (SRST) begin
		ctrl       <= `CTRL_RESET;
		save_name  <= 32'h00000000;
		rejected   <= 1'b0;
		slot_valid <= 8'h00;
		SETTINGS   <= `FACTORY_IMAGE;
		CMD_STROBE <= 1'b0;
		CMD_CODE   <= 6'h00;
		ALERT      <= 1'b0;
		ALERT_ROW  <= 5'h00;
		for (i = 0; i < `SLOTS; i = i + 1) begin
			slot_img[i]  <= 32'h00000000;
			slot_name[i] <= 32'h00000000;
			slot_mask[i] <= 4'h0;
		end
	end else begin
		CMD_STROBE <= 1'b0;
		ALERT      <= 1'b0;
		if (wr_now && WB_ADR_I == `A_CTRL) begin
			ctrl <= lane_merge(ctrl, WB_DAT_I, WB_SEL_I);
		end
		if (wr_now && WB_ADR_I == `A_NAME) begin
			save_name <= lane_merge(save_name, WB_DAT_I, WB_SEL_I);
		end
		if (wr_now && WB_ADR_I == `A_LIVE) begin
			SETTINGS <= lane_merge(SETTINGS, WB_DAT_I, WB_SEL_I);
		end
		if (wr_now && WB_ADR_I == `A_STAT && WB_SEL_I[0] && WB_DAT_I[0]) begin
			rejected <= 1'b0;
		end
		if (cmd_wr) begin
			if ((WB_DAT_I[`CMD_SAVE] | WB_DAT_I[`CMD_DELETE]) & prot) begin
				rejected <= 1'b1;
			end else if (WB_DAT_I[`CMD_SAVE]) begin
				slot_img[sel_slot]   <= SETTINGS & layer_bits(layers);
				slot_mask[sel_slot]  <= layers;
				slot_name[sel_slot]  <= save_name;
				slot_valid[sel_slot] <= 1'b1;
			end else if (WB_DAT_I[`CMD_DELETE]) begin
				slot_valid[sel_slot] <= 1'b0;
			end
			if (WB_DAT_I[`CMD_FACTORY]) begin
				SETTINGS <= `FACTORY_IMAGE;
			end else if (WB_DAT_I[`CMD_LOAD] && slot_valid[sel_slot]) begin
				// Only the preset's own layers change; empty slot changes nothing
				SETTINGS <= (SETTINGS & ~layer_bits(slot_mask[sel_slot])) |
					(slot_img[sel_slot] & layer_bits(slot_mask[sel_slot]));
			end
		end
		// Event action runs after bus updates so it overrides in the same cycle
		if (svc_go) begin
			case (svc_act)
				`ACT_PRESET: begin
					if (slot_valid[svc_arg[2:0]]) begin
						SETTINGS <= (SETTINGS & ~layer_bits(slot_mask[svc_arg[2:0]])) |
							(slot_img[svc_arg[2:0]] & layer_bits(slot_mask[svc_arg[2:0]]));
					end
				end
				`ACT_COMMAND: begin
					CMD_STROBE <= 1'b1;
					CMD_CODE   <= svc_arg;
				end
				`ACT_ALERT: begin
					ALERT     <= 1'b1;
					ALERT_ROW <= svc;
				end
				default: begin
				end
			endcase
		end
	end
end

endmodule // event_preset_engine

// File: sim/event_preset_engine_properties.sv
// Port level assertions for the event triggered preset engine
`timescale 1ns/1ps
module event_preset_engine_checker (
	input wire        CLK,
	input wire        SRST,
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_WE_I,
	input wire [9:0]  WB_ADR_I,
	input wire [3:0]  WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire        WB_ACK_O,
	input wire [31:0] SETTINGS,
	input wire        CMD_STROBE,
	input wire [5:0]  CMD_CODE,
	input wire        ALERT,
	input wire [4:0]  ALERT_ROW
);
	// ====================
	// Shadow of the event enable, so checks on bus effects can skip event races
	reg  en;
	wire req = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	always @(posedge CLK)
		if (SRST)
			en <= 1'b0;
		else if (req && WB_ADR_I == 10'h000)
			en <= WB_DAT_I[0];
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// ====================
	// Assertions
	a_ack_one_wait: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_data_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data outside ack");
	a_events_off_silent: assert property (!en && !$past(en) |-> !ALERT && !CMD_STROBE)
		else $error("action while events disabled");
	a_factory_clears: assert property (req && WB_ADR_I == 10'h004 && WB_DAT_I[3] && !en |=> SETTINGS == 32'h0)
		else $error("factory restore left settings");
	a_live_write: assert property (req && WB_ADR_I == 10'h010 && WB_SEL_I == 4'hF && !en |=> SETTINGS == $past(WB_DAT_I))
		else $error("live write lost");
	a_alert_row_holds: assert property (!ALERT |-> ALERT_ROW == $past(ALERT_ROW))
		else $error("alert row moved without alert");
	a_cmd_code_holds: assert property (!CMD_STROBE |-> $stable(CMD_CODE))
		else $error("command code moved without strobe");
	c_alert: cover property (ALERT);
	c_command: cover property (CMD_STROBE);
	c_factory: cover property (req && WB_ADR_I == 10'h004 && WB_DAT_I[3]);
endmodule // event_preset_engine_checker
bind event_preset_engine event_preset_engine_checker i_checker (.CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SETTINGS(SETTINGS), .CMD_STROBE(CMD_STROBE),
	.CMD_CODE(CMD_CODE), .ALERT(ALERT), .ALERT_ROW(ALERT_ROW));

// File: sim/status_source.sv
// Behavioural model of the card signal status detectors
`timescale 1ns/1ps
module status_source (
	input  wire       clk,
	output reg  [7:0] status
);
	initial status = 8'h00;
	// A lag of several cycles stands for a slow detector
	task automatic report(input logic [7:0] v, input int lag);
		repeat (lag) @(posedge clk);
		status <= v;
	endtask
endmodule // status_source

// File: sim/event_preset_engine_bench.sv
// Self-checking bench for the event triggered preset engine
`timescale 1ns/1ps
`include "preset_engine_defs.vh"
module event_preset_engine_bench;
	logic        clk, srst, cyc, stb, we, ack, strobe, alert;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, settings;
	logic [7:0]  status;
	logic [5:0]  code;
	logic [4:0]  arow;
	int          fail_count, tests_run;
	int          alert_n, strobe_n;
	// Count action pulses so each one-cycle output is seen while it stands
	always @(posedge clk) begin
		if (srst) begin
			alert_n <= 0;
			strobe_n <= 0;
		end else begin
			if (alert === 1'b1)
				alert_n <= alert_n + 1;
			if (strobe === 1'b1)
				strobe_n <= strobe_n + 1;
		end
	end
	event_preset_engine i_event_preset_engine (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.SIG_STATUS(status), .SETTINGS(settings), .CMD_STROBE(strobe), .CMD_CODE(code), .ALERT(alert),
		.ALERT_ROW(arow));
	status_source i_status_source (.clk(clk), .status(status));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ====================
	// Tasks
	task automatic end_of_test;
		$display("mismatches %0d, checks %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50) begin
			fail_count++;
			end_of_test;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// ====================
	// Sequence
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_of_test;
	end
	initial begin
		{srst, cyc, stb, we, adr, dat} = {1'b1, 3'h0, 10'h0, 32'h0};
		sel = 4'hF;
		fail_count = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(`A_CTRL, `CTRL_RESET);
		rd(10'h3FC, 32'h0);
		wr(`A_NAME, 32'h50524531);
		wr(`A_LIVE, 32'h11223344);
		wr(`A_CTRL, 32'h010);
		wr(`A_CMD, 32'h1);
		rd(`A_SLOT_NAME, 32'h50524531);
		wr(`A_LIVE, 32'hAABBCCDD);
		wr(`A_CMD, 32'h2);
		rd(`A_LIVE, 32'hAABBCC44);
		wr(`A_CMD, 32'h8);
		rd(`A_LIVE, 32'h0);
		wr(`A_ROW_BASE, 32'h80010404);
		wr(`A_ROW_BASE + 10'h4, 32'h80030101);
		wr(`A_ROW_BASE + 10'h7C, 32'h80160303);
		wr(`A_CTRL, 32'h011);
		i_status_source.report(8'h02, 1);
		repeat (8) @(posedge clk);
		rd(`A_ENGAGED, 32'h0);
		i_status_source.report(8'h07, 2);
		repeat (8) @(posedge clk);
		chk(settings, 32'h44);
		chk({26'h0, code}, 32'h5);
		chk({27'h0, arow}, 32'h1);
		chk(alert_n, 32'h1);
		chk(strobe_n, 32'h1);
		rd(`A_LOG_BASE, 32'h040);
		rd(`A_LOG_BASE + 10'h4, 32'h1C0);
		rd(`A_LOG_BASE + 10'h8, 32'h1F85);
		rd(`A_ROW_BASE, 32'h80010404);
		i_status_source.report(8'h00, 1);
		repeat (4) @(posedge clk);
		rd(`A_ENGAGED, 32'h80000003);
		chk(alert_n, 32'h1);
		wr(`A_CTRL, 32'h012);
		wr(`A_CMD, 32'h4);
		rd(`A_STAT, 32'h101);
		wr(`A_CTRL, 32'h010);
		wr(`A_CMD, 32'h4);
		rd(`A_STAT, 32'h1);
		wr(`A_LIVE, 32'h12345678);
		wr(`A_CMD, 32'h2);
		rd(`A_LIVE, 32'h12345678);
		end_of_test;
	end
endmodule // event_preset_engine_bench
